// [shared/tctrg_regs.vh]
/*
 Register offsets, field positions, encodings, reset values and timing
 counts of the trigger-mode timer/counter.
 Assumes a 100 MHz system clock that also serves as the high-frequency clock fc.
*/
`ifndef TCTRG_REGS_VH
`define TCTRG_REGS_VH

// Byte offsets on the register bus
`define TCTRG_OFS_CTRL 8'h00
`define TCTRG_OFS_CMPL 8'h04
`define TCTRG_OFS_CMPH 8'h08
`define TCTRG_OFS_CMPACT 8'h0c
`define TCTRG_OFS_CAPB 8'h10
`define TCTRG_OFS_CNT 8'h14
`define TCTRG_OFS_STAT 8'h18
`define TCTRG_OFS_MASK 8'h1c

// Control register field positions
`define TCTRG_START_LSB 0
`define TCTRG_CLKSEL_LSB 2
`define TCTRG_MODE_LSB 4
`define TCTRG_ACAP_BIT 6
`define TCTRG_METT_BIT 7
`define TCTRG_TAP_BIT 8

// Start control encodings
`define TCTRG_START_STOP 2'h0
`define TCTRG_START_CMD 2'h1
`define TCTRG_START_RISE 2'h2
`define TCTRG_START_FALL 2'h3

// Source clock select encodings
`define TCTRG_CLK_SLOW 2'h0
`define TCTRG_CLK_MID 2'h1
`define TCTRG_CLK_FAST 2'h2
`define TCTRG_CLK_PIN 2'h3

// Operating mode select; only the timer family is built
`define TCTRG_MODE_TIMER 2'h0

// Reset values
`define TCTRG_CTRL_RST 9'h000
`define TCTRG_CMPA_RST 16'hffff
`define TCTRG_CAPB_RST 16'h0000
`define TCTRG_MASK_RST 1'h0

// Prescaler taps as powers of two of fc, and of fs
`define TCTRG_TAP_SLOW 11
`define TCTRG_TAP_MID 7
`define TCTRG_TAP_FAST 3
`define TCTRG_FS_DIV 3

// Noise filter: a level must stand this long to pass
`define TCTRG_CLK_NS 10
`define TCTRG_FILT_NS 80
`define TCTRG_FILT_CYC (`TCTRG_FILT_NS / `TCTRG_CLK_NS)

`endif

// [src/tctrg_noise_filter.v]
/*
 Noise rejection for the timer input pin: the output follows the input only
 after the input has held a new level for the filter time.
 Assumes the input is already synchronised to clk.
*/
`timescale 1ns/1ps
`include "tctrg_regs.vh"

module tctrg_noise_filter (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Control
	input wire bypass,
	// Level in and out
	input wire levelIn,
	output reg levelOut
);

	localparam integer FILT_LAST = `TCTRG_FILT_CYC - 1;
	wire [31:0] filtLastW = FILT_LAST;
	reg [3:0] stable_r;

	// Pulses of 4 fc or less never reach 8 stable cycles; 12 fc or more always do
	always @(posedge clk) begin
		if (rst) begin
			stable_r <= 4'h0;
			levelOut <= 1'b0;
		end else if (bypass) begin
			stable_r <= 4'h0;
			levelOut <= levelIn;
		end else if (levelIn == levelOut) begin
			stable_r <= 4'h0;
		end else if (stable_r == filtLastW[3:0]) begin
			stable_r <= 4'h0;
			levelOut <= levelIn;
		end else begin
			stable_r <= stable_r + 4'h1;
		end
	end

endmodule

// [src/tctrg_timer.v]
/*
 16-bit up-counting timer with plain timer and external trigger timer modes,
 compare match, auto-capture, input noise filter and an AHB-Lite register slave.
 Assumes one 100 MHz clock (fc), whole-word single AHB transfers, a power
 controller driving stopModeReq and lowSpeedMode in the same clock domain.
*/
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "tctrg_regs.vh"

module tctrg_timer (
	// Clock and reset
	input wire clk,
	input wire rst,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Chip power state
	input wire stopModeReq,
	input wire lowSpeedMode,
	// Pins
	input wire timerInputPin,
	input wire lowFreqClk,
	// Interrupts
	output reg timerMatchIrq,
	output reg irq
);

	// Control fields
	reg [1:0] startCtrlField_r;
	reg [1:0] sourceClkSel_r;
	reg [1:0] opModeSel_r;
	reg autoCaptureEn_r;
	reg triggerStopSelect_r;
	reg prescalerTapSel_r;

	// Data path
	reg [7:0] cmpLow_r;
	reg [15:0] cmpPend_r;
	reg cmpPendValid_r;
	reg [15:0] compareRegA_r;
	reg [15:0] captureRegB_r;
	reg [15:0] count_r;
	reg running_r;

	// Interrupt status and mask
	reg status_r;
	reg status_nxt;
	reg mask_r;

	// Bus data phase
	reg wrPend_r;
	reg [7:0] wrAddr_r;
	reg [31:0] rdData_nxt;

	// Pin synchronisers, one per pin
	wire [1:0] pinsRaw;
	reg [1:0] syncA_r;
	reg [1:0] syncB_r;
	wire pinFiltered;
	reg pinPrev_r;
	reg fsPrev_r;
	reg [2:0] fsDiv_r;
	reg [10:0] prescale_r;

	wire addrPhase;
	wire rdReq;
	wire pinRise;
	wire pinFall;
	wire fsRise;
	wire fsTick;
	wire tickSlow;
	wire tickMid;
	wire tickFast;
	reg srcTick;
	wire trigEdge;
	wire oppEdge;
	wire cmpMatch;
	wire [8:0] ctrlRead;
	// Reset image of the control word, cut into its fields at reset
	wire [8:0] ctrlRst = `TCTRG_CTRL_RST;

	assign pinsRaw = {lowFreqClk, timerInputPin};

	// Both pins are asynchronous; only the second stage feeds any logic
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (rst) begin
					syncA_r[gi] <= 1'b0;
					syncB_r[gi] <= 1'b0;
				end else begin
					syncA_r[gi] <= pinsRaw[gi];
					syncB_r[gi] <= syncA_r[gi];
				end
			end
		end
	endgenerate

	tctrg_noise_filter u_filter (
		.clk(clk),
		.rst(rst),
		.bypass(lowSpeedMode),
		.levelIn(syncB_r[0]),
		.levelOut(pinFiltered)
	);

	// Edge detection and clock division
	// The prescaler runs free from reset, so the first tick after a start comes early
	always @(posedge clk) begin
		if (rst) begin
			pinPrev_r <= 1'b0;
			fsPrev_r <= 1'b0;
			fsDiv_r <= 3'h0;
			prescale_r <= 11'h000;
		end else begin
			pinPrev_r <= pinFiltered;
			fsPrev_r <= syncB_r[1];
			prescale_r <= prescale_r + 11'h001;
			if (fsRise) begin
				fsDiv_r <= fsDiv_r + 3'h1;
			end
		end
	end

	assign pinRise = pinFiltered & ~pinPrev_r;
	assign pinFall = ~pinFiltered & pinPrev_r;
	assign fsRise = syncB_r[1] & ~fsPrev_r;
	assign fsTick = fsRise & (&fsDiv_r[`TCTRG_FS_DIV-1:0]);
	assign tickSlow = &prescale_r[`TCTRG_TAP_SLOW-1:0];
	assign tickMid = &prescale_r[`TCTRG_TAP_MID-1:0];
	assign tickFast = &prescale_r[`TCTRG_TAP_FAST-1:0];

	// Faster taps have no low-speed equivalent and give no ticks there
	always @* begin
		case (sourceClkSel_r)
			`TCTRG_CLK_SLOW: srcTick = (prescalerTapSel_r | lowSpeedMode) ? fsTick : tickSlow;
			`TCTRG_CLK_MID: srcTick = tickMid & ~lowSpeedMode;
			`TCTRG_CLK_FAST: srcTick = tickFast & ~lowSpeedMode;
			`TCTRG_CLK_PIN: srcTick = pinRise;
			default: srcTick = 1'b0;
		endcase
	end

	// Polarity follows the start field; the stop and command codes never use these edges
	assign trigEdge = (startCtrlField_r == `TCTRG_START_RISE) ? pinRise : pinFall;
	assign oppEdge = (startCtrlField_r == `TCTRG_START_RISE) ? pinFall : pinRise;
	// Compared before the increment, so a period is compare plus one ticks
	assign cmpMatch = (count_r == compareRegA_r);

	// Counter core
	// Priority: stop code, command mode, idle wait, abort edge, then the tick
	always @(posedge clk) begin
		if (rst) begin
			count_r <= 16'h0000;
			running_r <= 1'b0;
			timerMatchIrq <= 1'b0;
		end else begin
			timerMatchIrq <= 1'b0;
			// Modes other than the timer family are held stopped
			if (startCtrlField_r == `TCTRG_START_STOP || opModeSel_r != `TCTRG_MODE_TIMER) begin
				count_r <= 16'h0000;
				running_r <= 1'b0;
			end else if (startCtrlField_r == `TCTRG_START_CMD) begin
				running_r <= 1'b1;
				if (srcTick) begin
					if (cmpMatch) begin
						count_r <= 16'h0000;
						timerMatchIrq <= 1'b1;
					end else begin
						count_r <= count_r + 16'h0001;
					end
				end
			end else if (!running_r) begin
				if (trigEdge) begin
					running_r <= 1'b1;
					count_r <= 16'h0000;
				end
			end else if (triggerStopSelect_r && oppEdge) begin
				running_r <= 1'b0;
				count_r <= 16'h0000;
			end else if (srcTick) begin
				// A trigger edge while running falls through here unused
				if (cmpMatch) begin
					running_r <= 1'b0;
					count_r <= 16'h0000;
					timerMatchIrq <= 1'b1;
				end else begin
					count_r <= count_r + 16'h0001;
				end
			end
		end
	end

	// Compare staging and auto-capture, both paced by the source tick
	always @(posedge clk) begin
		if (rst) begin
			compareRegA_r <= `TCTRG_CMPA_RST;
			cmpPend_r <= `TCTRG_CMPA_RST;
			cmpPendValid_r <= 1'b0;
			cmpLow_r <= 8'h00;
			captureRegB_r <= `TCTRG_CAPB_RST;
		end else begin
			if (wrPend_r && wrAddr_r == `TCTRG_OFS_CMPL) begin
				cmpLow_r <= hwdata[7:0];
			end
			if (wrPend_r && wrAddr_r == `TCTRG_OFS_CMPH) begin
				cmpPend_r <= {hwdata[7:0], cmpLow_r};
				cmpPendValid_r <= 1'b1;
			end else if (srcTick && cmpPendValid_r) begin
				compareRegA_r <= cmpPend_r;
				cmpPendValid_r <= 1'b0;
			end
			if (srcTick && autoCaptureEn_r) begin
				captureRegB_r <= count_r;
			end
		end
	end

	// Bus address phase: reads are answered with no wait state
	// Size and upper address bits are not decoded: every register is one whole word
	assign addrPhase = hsel & htrans[1] & hready;
	assign rdReq = addrPhase & ~hwrite;
	assign ctrlRead = {prescalerTapSel_r, triggerStopSelect_r, autoCaptureEn_r,
		opModeSel_r, sourceClkSel_r, startCtrlField_r};

	always @* begin
		case (haddr[7:0])
			`TCTRG_OFS_CTRL: rdData_nxt = {23'h000000, ctrlRead};
			`TCTRG_OFS_CMPL: rdData_nxt = {24'h000000, cmpLow_r};
			`TCTRG_OFS_CMPH: rdData_nxt = {24'h000000, cmpPend_r[15:8]};
			`TCTRG_OFS_CMPACT: rdData_nxt = {16'h0000, compareRegA_r};
			`TCTRG_OFS_CAPB: rdData_nxt = {16'h0000, captureRegB_r};
			`TCTRG_OFS_CNT: rdData_nxt = {16'h0000, count_r};
			`TCTRG_OFS_STAT: rdData_nxt = {31'h00000000, status_r};
			`TCTRG_OFS_MASK: rdData_nxt = {31'h00000000, mask_r};
			default: rdData_nxt = 32'h00000000;
		endcase
	end

	// A match in the cycle of a status read survives the clear
	always @* begin
		status_nxt = status_r;
		if (rdReq && haddr[7:0] == `TCTRG_OFS_STAT) begin
			status_nxt = 1'b0;
		end
		if (timerMatchIrq) begin
			status_nxt = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend_r <= addrPhase & hwrite;
			if (addrPhase) begin
				wrAddr_r <= haddr[7:0];
			end
			if (rdReq) begin
				hrdata <= rdData_nxt;
			end
		end
	end

	// Status and level share one block so the level never lags a clear
	always @(posedge clk) begin
		if (rst) begin
			status_r <= 1'b0;
			irq <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq <= status_nxt & mask_r;
		end
	end

	// Control writes land in the data phase
	always @(posedge clk) begin
		if (rst) begin
			startCtrlField_r <= ctrlRst[`TCTRG_START_LSB+1:`TCTRG_START_LSB];
			sourceClkSel_r <= ctrlRst[`TCTRG_CLKSEL_LSB+1:`TCTRG_CLKSEL_LSB];
			opModeSel_r <= ctrlRst[`TCTRG_MODE_LSB+1:`TCTRG_MODE_LSB];
			autoCaptureEn_r <= ctrlRst[`TCTRG_ACAP_BIT];
			triggerStopSelect_r <= ctrlRst[`TCTRG_METT_BIT];
			prescalerTapSel_r <= ctrlRst[`TCTRG_TAP_BIT];
		end else begin
			if (wrPend_r && wrAddr_r == `TCTRG_OFS_CTRL) begin
				startCtrlField_r <= hwdata[`TCTRG_START_LSB+1:`TCTRG_START_LSB];
				sourceClkSel_r <= hwdata[`TCTRG_CLKSEL_LSB+1:`TCTRG_CLKSEL_LSB];
				opModeSel_r <= hwdata[`TCTRG_MODE_LSB+1:`TCTRG_MODE_LSB];
				autoCaptureEn_r <= hwdata[`TCTRG_ACAP_BIT];
				triggerStopSelect_r <= hwdata[`TCTRG_METT_BIT];
				prescalerTapSel_r <= hwdata[`TCTRG_TAP_BIT];
			end
			// Power-down wins over the start field of any write in the same cycle; the other fields of that write still land
			if (stopModeReq) begin
				startCtrlField_r <= `TCTRG_START_STOP;
			end
		end
	end

	// Mask changes reach the interrupt level one cycle after the write lands
	always @(posedge clk) begin
		if (rst) begin
			mask_r <= `TCTRG_MASK_RST;
		end else if (wrPend_r && wrAddr_r == `TCTRG_OFS_MASK) begin
			mask_r <= hwdata[0];
		end
	end

endmodule

// [verification/tctrg_timer_asserts.sv]
/*
 Port-level checker for the trigger-mode timer.
 Assumes one clock, synchronous active-high reset, bound to tctrg_timer.
*/
`timescale 1ns/1ps
module tctrg_timer_chk (
	// Clock and reset
	input logic clk,
	input logic rst,
	// Register bus
	input logic hsel,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic [31:0] hrdata,
	input logic hreadyout,
	input logic hresp,
	// Power and events
	input logic stopModeReq,
	input logic timerMatchIrq,
	input logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Fastest source tick outside low-speed mode is eight clocks, so matches are never closer there; the unfiltered pin can tick every two
	sequence s_gap;
		!timerMatchIrq[*7];
	endsequence
	sequence s_quiet;
		(!htrans[1])[*3];
	endsequence
	property p_pulseGap;
		timerMatchIrq |=> s_gap;
	endproperty
	property p_irqCause;
		$rose(irq) |-> $past(timerMatchIrq);
	endproperty
	property p_stopMode;
		stopModeReq[*3] |-> !timerMatchIrq;
	endproperty
	property p_rstQuiet;
		disable iff (1'b0) rst |=> !irq && !timerMatchIrq && hreadyout;
	endproperty
	property p_okay;
		!hresp;
	endproperty
	property p_noWait;
		hreadyout;
	endproperty
	property p_hold;
		!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
	endproperty
	property p_irqHold;
		s_quiet ##0 irq |=> irq;
	endproperty
	a_pulseGap: assert property (p_pulseGap) else $error("match pulse too long");
	a_irqCause: assert property (p_irqCause) else $error("irq without match");
	a_stopMode: assert property (p_stopMode) else $error("match in stop mode");
	a_rstQuiet: assert property (p_rstQuiet) else $error("outputs live in reset");
	a_okay: assert property (p_okay) else $error("error response");
	a_noWait: assert property (p_noWait) else $error("wait state");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_irqHold: assert property (p_irqHold) else $error("irq dropped alone");
endmodule
bind tctrg_timer tctrg_timer_chk u_chk (.clk, .rst, .hsel, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .stopModeReq, .timerMatchIrq, .irq);

// [verification/tctrg_pulse_src.sv]
/*
 External pulse source on the timer input pin.
 Assumes the bench sets the idle level and fires inverted pulses.
*/
`timescale 1ns/1ps
module tctrg_pulse_src (
	// Clock
	input logic clk,
	// Requests
	input logic level,
	input logic fire,
	input logic [7:0] pulseLen,
	// Pin
	output logic pin
);
	logic [7:0] left;
	initial begin
		pin = 1'b0;
		left = 8'h00;
	end
	// Levels change only on clock edges, so each lasts whole cycles
	always @(posedge clk) begin
		if (fire) begin
			left <= pulseLen;
			pin <= !level;
		end else if (left > 8'h01) begin
			left <= left - 8'h01;
		end else begin
			left <= 8'h00;
			pin <= level;
		end
	end
endmodule

// [verification/tctrg_timer_bench.sv]
/*
 Self-checking bench for the trigger-mode timer.
 Assumes zero-wait AHB-Lite slave and a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "tctrg_regs.vh"
module tctrg_timer_bench;
	logic clk, rst, hsel, hwrite, stopModeReq, lowSpeedMode, lowFreqClk;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic hreadyout, hresp, timerMatchIrq, irq, pin, level, fire, hit;
	logic [7:0] pulseLen;
	int n_mismatch = 0;
	int n_checks = 0;
	tctrg_timer u_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .stopModeReq, .lowSpeedMode,
		.timerInputPin(pin), .lowFreqClk, .timerMatchIrq, .irq);
	tctrg_pulse_src u_src (.clk, .level, .fire, .pulseLen, .pin);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// The low-frequency clock runs free at one eighth of clk
	initial begin
		lowFreqClk = 1'b0;
		forever begin
			repeat (4) @(posedge clk);
			lowFreqClk <= ~lowFreqClk;
		end
	end
	task automatic report_and_stop;
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic waitReady;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			report_and_stop;
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		waitReady;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady;
		q = hrdata;
	endtask
	task automatic waitMatch(input int lim);
		hit = 1'b0;
		for (int i = 0; i < lim && !hit; i++) begin
			@(posedge clk);
			hit = (timerMatchIrq === 1'b1);
		end
	endtask
	task automatic pulse(input logic [7:0] len);
		@(posedge clk);
		pulseLen <= len;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	// Mode and clock may only change while stopped
	task automatic setup(input logic [31:0] ctrl, input logic [15:0] cmp);
		xfer(1'b1, `TCTRG_OFS_CTRL, 32'h0);
		xfer(1'b1, `TCTRG_OFS_CMPL, {24'h0, cmp[7:0]});
		xfer(1'b1, `TCTRG_OFS_CMPH, {24'h0, cmp[15:8]});
		xfer(1'b1, `TCTRG_OFS_CTRL, ctrl);
	endtask
	task automatic t_reset;
		xfer(1'b1, 8'h40, 32'h5a);
		xfer(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		xfer(1'b0, `TCTRG_OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		xfer(1'b0, `TCTRG_OFS_CMPACT, 32'h0);
		chk(q, 32'h0000ffff);
		xfer(1'b0, `TCTRG_OFS_CAPB, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic t_timer;
		int n;
		xfer(1'b1, `TCTRG_OFS_MASK, 32'h1);
		setup(32'h49, 16'h0002);
		waitMatch(100);
		chk({31'h0, hit}, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b0, `TCTRG_OFS_STAT, 32'h0);
		chk(q, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, `TCTRG_OFS_MASK, 32'h0);
		waitMatch(100);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (timerMatchIrq !== 1'b1 && n < 100);
		chk(n, 24);
		xfer(1'b0, `TCTRG_OFS_CAPB, 32'h0);
		chk(q, 32'h2);
		xfer(1'b1, `TCTRG_OFS_CMPL, 32'h05);
		repeat (20) @(posedge clk);
		xfer(1'b0, `TCTRG_OFS_CMPACT, 32'h0);
		chk(q, 32'h2);
		xfer(1'b1, `TCTRG_OFS_CMPH, 32'h0);
		repeat (20) @(posedge clk);
		xfer(1'b0, `TCTRG_OFS_CMPACT, 32'h0);
		chk(q, 32'h5);
		stopModeReq <= 1'b1;
		repeat (3) @(posedge clk);
		stopModeReq <= 1'b0;
		xfer(1'b0, `TCTRG_OFS_CTRL, 32'h0);
		chk({30'h0, q[1:0]}, 32'h0);
	endtask
	// Rising start, compare 4 at eight clocks a tick: a run lasts some 40 clocks
	task automatic t_trig(input logic stopSel);
		level <= 1'b0;
		setup({24'h0, stopSel, 7'h0a}, 16'h0004);
		pulse(8'h03);
		waitMatch(100);
		chk({31'h0, hit}, 32'h0);
		level <= 1'b1;
		waitMatch(150);
		chk({31'h0, hit}, 32'h1);
		xfer(1'b0, `TCTRG_OFS_CNT, 32'h0);
		chk(q, 32'h0);
		level <= 1'b0;
		repeat (30) @(posedge clk);
		pulse(8'h0f);
		repeat (25) @(posedge clk);
		pulse(8'h0f);
		waitMatch(40);
		chk({31'h0, hit}, {31'h0, !stopSel});
		repeat (60) @(posedge clk);
		level <= 1'b1;
		waitMatch(150);
		chk({31'h0, hit}, 32'h1);
	endtask
	// Low speed: filter bypassed, slow tap from fs/8, 64 clocks a tick
	task automatic t_slow;
		int n;
		level <= 1'b0;
		lowSpeedMode <= 1'b1;
		setup(32'h02, 16'h0001);
		repeat (70) @(posedge clk);
		pulse(8'h03);
		waitMatch(200);
		chk({31'h0, hit}, 32'h1);
		setup(32'h01, 16'h0001);
		waitMatch(300);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (timerMatchIrq !== 1'b1 && n < 300);
		chk(n, 128);
		lowSpeedMode <= 1'b0;
	endtask
	// Pin as source clock: each filtered rising edge is one tick
	task automatic t_pinclk;
		setup(32'h0d, 16'h0002);
		repeat (2) begin
			pulse(8'h0f);
			repeat (30) @(posedge clk);
		end
		xfer(1'b0, `TCTRG_OFS_CNT, 32'h0);
		chk(q, 32'h2);
		pulse(8'h0f);
		waitMatch(40);
		chk({31'h0, hit}, 32'h1);
	endtask
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		stopModeReq = 1'b0;
		lowSpeedMode = 1'b0;
		level = 1'b0;
		fire = 1'b0;
		pulseLen = 8'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_timer;
		t_trig(1'b1);
		t_trig(1'b0);
		t_slow;
		t_pinclk;
		report_and_stop;
	end
	initial begin
		repeat (50000) @(posedge clk);
		n_mismatch++;
		report_and_stop;
	end
endmodule
